// ===== gdio_defines.vh
// Purpose: constants for the general digital io port block
// Assumes: 32-bit axi4-lite register bus, 8-bit ports
// Notes:   byte offsets of the software registers
`ifndef GDIO_DEFINES_VH
`define GDIO_DEFINES_VH
`define GDIO_PORT_WIDTH     8
`define GDIO_NUM_PORTS      2
`define GDIO_OFF_DIR0       12'h000
`define GDIO_OFF_DRV0       12'h004
`define GDIO_OFF_LVL0       12'h008
`define GDIO_OFF_DIR1       12'h010
`define GDIO_OFF_DRV1       12'h014
`define GDIO_OFF_LVL1       12'h018
`define GDIO_OFF_SFIO       12'h020
`define GDIO_OFF_IRQSTAT    12'h024
`define GDIO_OFF_IRQMASK    12'h028
`define GDIO_OFF_EXTEN      12'h02c
`define GDIO_SFIO_PUD_BIT   0
`define GDIO_RESP_OKAY      2'h0
`define GDIO_RESP_SLVERR    2'h2
`endif

// ===== gdio_pin_slice.v
// Purpose: one pad slice: driver, pull-up, sleep clamp, input sync
// Assumes: clkSys is the io clock; rstN is active low, synchronised copy
// Notes:   pad pull-up and enable are combinational, so reset tri-states
//          the pad at once through the registered direction bits
module gdio_pin_slice (
  input  wire clkSys,
  input  wire rstN,
  input  wire dirBit,
  input  wire drvBit,
  input  wire pullupDisable,
  input  wire sleepClamp,
  input  wire extIntEnable,
  input  wire padIn,
  output wire padOut,
  output wire padOe,
  output wire padPullup,
  output reg  levelBit,
  output wire clampedIn
);
  reg syncLatch;

  assign padOe     = dirBit;
  assign padOut    = drvBit;
  assign padPullup = rstN & ~dirBit & drvBit & ~pullupDisable;
  // clamp ahead of the buffer unless the external interrupt keeps it open
  assign clampedIn = padIn & ~(sleepClamp & ~extIntEnable);

  // latch is transparent while the clock is high, holds while it is low
  always @* begin
    if (clkSys) begin
      syncLatch = clampedIn;
    end else begin
      syncLatch = syncLatch;
    end
  end

  always @(posedge clkSys or negedge rstN) begin
    if (!rstN) begin
      levelBit <= 1'b0;
    end else begin
      levelBit <= syncLatch;
    end
  end
endmodule

// ===== gdio_port.v
// Purpose: bank of general digital io ports behind an axi4-lite slave
// Assumes: clk_sys at 25 MHz, rst_n active low asynchronous
// Notes:   pads split into in, out, output enable and pull-up enable
//
// Implementation choices: register access over AXI4-Lite and the address map.
`include "gdio_defines.vh"

// Notes on behaviour
// - direction bit one drives the pin; zero makes it an input
// - input with drive value one enables pull-up unless globally disabled
// - pull-up off when drive value is zero or pin is output
// - reset tri-states every pin, even without a running clock
// - output pin drives high for value one, low for zero
// - global pull-up disable leaves value-one inputs tri-stated
// - sampled level is readable whatever the direction
// - input latch transparent while clock high, registered next rise
// - pin change reaches the level bit after half to one and half periods
// - a written value reaches the level bit one clock later
// - deep sleep states clamp digital inputs to ground
// - clamp bypassed for pins with external interrupt enabled
// - high level on disabled edge interrupt pin of port 0 sets flag on wake
// - configured pull-ups are inactive during reset
// - level registers read-only; direction and drive registers read-write
module gdio_port (
  clk_sys,
  rst_n,
  awaddr,
  awvalid,
  awready,
  wdata,
  wstrb,
  wvalid,
  wready,
  bresp,
  bvalid,
  bready,
  araddr,
  arvalid,
  arready,
  rdata,
  rresp,
  rvalid,
  rready,
  sleepDeep,
  padIn,
  padOut,
  padOe,
  padPullup,
  irq
);
  localparam W  = `GDIO_PORT_WIDTH;
  localparam NP = `GDIO_NUM_PORTS;
  localparam NB = W * NP;

  input  wire          clk_sys;
  input  wire          rst_n;
  input  wire [11:0]   awaddr;
  input  wire          awvalid;
  output reg           awready;
  input  wire [31:0]   wdata;
  input  wire [3:0]    wstrb;
  input  wire          wvalid;
  output reg           wready;
  output reg  [1:0]    bresp;
  output reg           bvalid;
  input  wire          bready;
  input  wire [11:0]   araddr;
  input  wire          arvalid;
  output reg           arready;
  output reg  [31:0]   rdata;
  output reg  [1:0]    rresp;
  output reg           rvalid;
  input  wire          rready;
  input  wire          sleepDeep;
  input  wire [NB-1:0] padIn;
  output wire [NB-1:0] padOut;
  output wire [NB-1:0] padOe;
  output wire [NB-1:0] padPullup;
  output reg           irq;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  reg rstMeta_reg;
  reg rstN_reg;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_reg <= 1'b0;
      rstN_reg    <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstN_reg    <= rstMeta_reg;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg  [NB-1:0] dir_reg;
  reg  [NB-1:0] drv_reg;
  reg  [NB-1:0] extEn_reg;
  reg  [NB-1:0] irqStat_reg;
  reg  [NB-1:0] irqMask_reg;
  reg  [NB-1:0] prevLvl_reg;
  reg           pud_reg;
  reg           sleepMeta_reg;
  reg           sleep_reg;
  reg           sleepPrev_reg;
  wire [NB-1:0] lvl;
  wire [NB-1:0] clampedIn;
  wire [NB-1:0] oeNow;
  wire [NB-1:0] outNow;
  wire [NB-1:0] puNow;

  // pads are driven straight from flip-flops; rst_n gates them so the
  // pins tri-state at once, before the synchronised reset catches up
  assign padOe     = oeNow & {NB{rst_n}};
  assign padOut    = outNow;
  assign padPullup = puNow & {NB{rst_n}};

  genvar g;
  generate
    for (g = 0; g < NB; g = g + 1) begin : slice
      gdio_pin_slice u_slice (
        .clkSys        (clk_sys),
        .rstN          (rstN_reg),
        .dirBit        (dir_reg[g]),
        .drvBit        (drv_reg[g]),
        .pullupDisable (pud_reg),
        .sleepClamp    (sleep_reg),
        .extIntEnable  (extEn_reg[g]),
        .padIn         (padIn[g]),
        .padOut        (outNow[g]),
        .padOe         (oeNow[g]),
        .padPullup     (puNow[g]),
        .levelBit      (lvl[g]),
        .clampedIn     (clampedIn[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function [3:0] gdioDecode;
    input [11:0] a;
    begin
      case (a)
        `GDIO_OFF_DIR0:    gdioDecode = 4'h1;
        `GDIO_OFF_DRV0:    gdioDecode = 4'h2;
        `GDIO_OFF_LVL0:    gdioDecode = 4'h3;
        `GDIO_OFF_DIR1:    gdioDecode = 4'h4;
        `GDIO_OFF_DRV1:    gdioDecode = 4'h5;
        `GDIO_OFF_LVL1:    gdioDecode = 4'h6;
        `GDIO_OFF_SFIO:    gdioDecode = 4'h7;
        `GDIO_OFF_IRQSTAT: gdioDecode = 4'h8;
        `GDIO_OFF_IRQMASK: gdioDecode = 4'h9;
        `GDIO_OFF_EXTEN:   gdioDecode = 4'ha;
        default:           gdioDecode = 4'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // write channel
  // ----------------------------------------------------------------
  reg  [11:0] awAddr_reg;
  reg         awHave_reg;
  reg  [7:0]  wByte_reg;
  reg         wByteEn_reg;
  reg         wHave_reg;
  wire        doWrite = awHave_reg & wHave_reg & ~bvalid;
  wire [3:0]  wSel    = gdioDecode(awAddr_reg);
  // only the low byte holds data; upper lanes are ignored
  wire        wLow    = doWrite & wByteEn_reg;

  always @(posedge clk_sys or negedge rstN_reg) begin
    if (!rstN_reg) begin
      awready     <= 1'b0;
      wready      <= 1'b0;
      awHave_reg  <= 1'b0;
      wHave_reg   <= 1'b0;
      awAddr_reg  <= 12'h000;
      wByte_reg   <= 8'h00;
      wByteEn_reg <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= `GDIO_RESP_OKAY;
      dir_reg     <= {NB{1'b0}};
      drv_reg     <= {NB{1'b0}};
      pud_reg     <= 1'b0;
      extEn_reg   <= {NB{1'b0}};
      irqMask_reg <= {NB{1'b0}};
    end else begin
      awready <= ~awHave_reg & ~awready & awvalid;
      wready  <= ~wHave_reg & ~wready & wvalid;
      if (awvalid && awready) begin
        awHave_reg <= 1'b1;
        awAddr_reg <= awaddr;
      end
      if (wvalid && wready) begin
        wHave_reg   <= 1'b1;
        wByte_reg   <= wdata[7:0];
        wByteEn_reg <= wstrb[0];
      end
      if (doWrite) begin
        awHave_reg <= 1'b0;
        wHave_reg  <= 1'b0;
        bvalid     <= 1'b1;
        if (wSel == 4'h0) begin
          bresp <= `GDIO_RESP_SLVERR;
        end else begin
          bresp <= `GDIO_RESP_OKAY;
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (wLow) begin
        case (wSel)
          4'h1: dir_reg[W-1:0]     <= wByte_reg;
          4'h2: drv_reg[W-1:0]     <= wByte_reg;
          4'h4: dir_reg[NB-1:W]    <= wByte_reg;
          4'h5: drv_reg[NB-1:W]    <= wByte_reg;
          4'h7: pud_reg <= wByte_reg[`GDIO_SFIO_PUD_BIT];
          4'h9: irqMask_reg[W-1:0] <= wByte_reg;
          4'ha: extEn_reg[W-1:0]   <= wByte_reg;
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  wire [3:0] rSel = gdioDecode(araddr);
  reg  [7:0] rByte;
  always @* begin
    case (rSel)
      4'h1:    rByte = dir_reg[W-1:0];
      4'h2:    rByte = drv_reg[W-1:0];
      4'h3:    rByte = lvl[W-1:0];
      4'h4:    rByte = dir_reg[NB-1:W];
      4'h5:    rByte = drv_reg[NB-1:W];
      4'h6:    rByte = lvl[NB-1:W];
      4'h7:    rByte = {7'h00, pud_reg};
      4'h8:    rByte = irqStat_reg[W-1:0];
      4'h9:    rByte = irqMask_reg[W-1:0];
      4'ha:    rByte = extEn_reg[W-1:0];
      default: rByte = 8'h00;
    endcase
  end

  wire readTake = arvalid & arready;
  wire statRead = readTake & (rSel == 4'h8);

  always @(posedge clk_sys or negedge rstN_reg) begin
    if (!rstN_reg) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `GDIO_RESP_OKAY;
    end else begin
      arready <= ~arready & ~rvalid & arvalid;
      if (readTake) begin
        rvalid <= 1'b1;
        rdata  <= {24'h000000, rByte};
        if (rSel == 4'h0) begin
          rresp <= `GDIO_RESP_SLVERR;
        end else begin
          rresp <= `GDIO_RESP_OKAY;
        end
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sleep sync, wake-up edge flags, interrupt
  // ----------------------------------------------------------------
  // the clamp drives inputs low, so a high pin with its interrupt off
  // reads as a rising edge on wake; the flag sets then for port 0 pins only
  wire [NB-1:0] riseEv = lvl & ~prevLvl_reg;
  wire [NB-1:0] statNext;
  assign statNext = (statRead ? {NB{1'b0}} : irqStat_reg)
                    | {{(NB-W){1'b0}}, riseEv[W-1:0]};

  always @(posedge clk_sys or negedge rstN_reg) begin
    if (!rstN_reg) begin
      sleepMeta_reg <= 1'b0;
      sleep_reg     <= 1'b0;
      sleepPrev_reg <= 1'b0;
      prevLvl_reg   <= {NB{1'b0}};
      irqStat_reg   <= {NB{1'b0}};
      irq           <= 1'b0;
    end else begin
      sleepMeta_reg <= sleepDeep;
      sleep_reg     <= sleepMeta_reg;
      sleepPrev_reg <= sleep_reg;
      prevLvl_reg   <= lvl;
      // set beats the read clear
      irqStat_reg   <= statNext;
      irq           <= |(statNext & irqMask_reg);
    end
  end
endmodule

// ===== gdio_pad_model.sv
// Purpose: pads and outside drivers seen by the io port block
// Assumes: an outside driver beats the weak pull-up
// Notes:   an undriven pin reads low, as if a weak board pull-down held it
module gdio_pad_model (
  input  wire logic        clkSys,
  input  wire logic [15:0] padOut,
  input  wire logic [15:0] padOe,
  input  wire logic [15:0] padPullup,
  input  wire logic [15:0] extEn,
  input  wire logic [15:0] extVal,
  output logic      [15:0] padIn
);
  timeunit 1ns;
  timeprecision 1ps;
  // resolve each wire from every party that may drive it; a level that
  // wanders would set sticky edge flags nobody could predict
  always_comb begin
    padIn = (padOe & padOut)
          | (~padOe & extEn & extVal)
          | (~padOe & ~extEn & padPullup);
  end
endmodule

// ===== gdio_port_assertions.sv
// Purpose: port-level checks for the io port block
// Assumes: one clock domain, rst_n active low
// Notes:   the reset check stays live while reset is held
module gdio_port_assertions (
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [15:0] padOe,
  input wire logic [15:0] padPullup
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_reset_tri;
    @(posedge clk_sys) disable iff (1'b0)
    !rst_n |-> padOe == 16'h0000 && padPullup == 16'h0000;
  endproperty
  a_reset_tri: assert property (p_reset_tri)
    else $error("pad active during reset");
  property p_pull_oe;
    (padPullup & padOe) == 16'h0000;
  endproperty
  a_pull_oe: assert property (p_pull_oe)
    else $error("pull-up on a driven pin");
  property p_ar_pulse;
    arready |=> !arready;
  endproperty
  a_ar_pulse: assert property (p_ar_pulse) else $error("arready held");
  property p_aw_valid;
    awready |-> awvalid;
  endproperty
  a_aw_valid: assert property (p_aw_valid) else $error("awready unasked");
  property p_read_ans;
    arvalid && arready |=> rvalid;
  endproperty
  a_read_ans: assert property (p_read_ans) else $error("rvalid late");
  property p_b_ans;
    awvalid && awready |-> ##[1:3] bvalid;
  endproperty
  a_b_ans: assert property (p_b_ans) else $error("bvalid late");
  property p_b_once;
    bvalid && bready |=> !bvalid;
  endproperty
  a_b_once: assert property (p_b_once) else $error("bvalid repeated");
  property p_r_once;
    rvalid && rready |=> !rvalid;
  endproperty
  a_r_once: assert property (p_r_once) else $error("rvalid repeated");
endmodule

// ===== gdio_port_tb_top.sv
// Purpose: self-checking bench for the io port block
// Assumes: axi4-lite master tasks, pad model on the far side
// Notes:   pins the model leaves undriven read low
`include "gdio_defines.vh"
module gdio_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, rst_n = 1'b0, sleepDeep = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, lastResp;
  logic [15:0] padIn, padOut, padOe, padPullup;
  logic [15:0] extEn = 16'h500f, extVal = 16'h0000;
  int fails = 0, nTests = 0, cyc = 0;
  always #20 clk_sys = ~clk_sys;
  gdio_port dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .sleepDeep(sleepDeep), .padIn(padIn),
    .padOut(padOut), .padOe(padOe), .padPullup(padPullup), .irq(irq));
  gdio_pad_model pad_u (.clkSys(clk_sys), .padOut(padOut), .padOe(padOe),
    .padPullup(padPullup), .extEn(extEn), .extVal(extVal), .padIn(padIn));
  // ----------------------------------------------------------------
  // bus tasks and checks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("fails=%0d nTests=%0d", fails, nTests);
    if (fails == 0 && nTests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge clk_sys);
      if (awready === 1'b1 && !ad) begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1 && !wd) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk_sys);
    lastResp = bresp;
    bready <= 1'b0;
    tick(2);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk_sys); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk_sys);
    lastResp = rresp;
    rready <= 1'b0;
    chk(rdata, exp);
    tick(1);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      finish_test();
    end
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    tick(4);
    rst_n <= 1'b1;
    tick(4);
    rdc(`GDIO_OFF_DIR0, 32'h0);
    rdc(`GDIO_OFF_DRV0, 32'h0);
    wr(`GDIO_OFF_DRV0, 32'hf0);
    chk(padPullup, 32'h00f0);
    rdc(`GDIO_OFF_LVL0, 32'hf0);
    wr(`GDIO_OFF_SFIO, 32'h1);
    chk(padPullup, 32'h0);
    wr(`GDIO_OFF_SFIO, 32'h0);
    wr(`GDIO_OFF_DIR0, 32'hff);
    chk({padOe, padOut & padOe}, 32'h00ff00f0);
    chk(padPullup, 32'h0);
    rdc(`GDIO_OFF_LVL0, 32'hf0);
    rdc(`GDIO_OFF_DIR0, 32'hff);
    wr(`GDIO_OFF_LVL0, 32'h55);
    rdc(`GDIO_OFF_LVL0, 32'hf0);
    rdc(12'h100, 32'h0);
    chk(lastResp, `GDIO_RESP_SLVERR);
    wr(`GDIO_OFF_DIR1, 32'h0f);
    wr(`GDIO_OFF_DRV1, 32'ha5);
    chk(padOe, 32'h0fff);
    rdc(`GDIO_OFF_LVL1, 32'ha5);
    wr(`GDIO_OFF_DIR0, 32'h0);
    wr(`GDIO_OFF_DRV0, 32'h0);
    wr(`GDIO_OFF_IRQMASK, 32'h1);
    rdc(`GDIO_OFF_IRQSTAT, 32'hf0);
    rdc(`GDIO_OFF_IRQSTAT, 32'h0);
    extVal <= 16'h0002;
    tick(4);
    chk(irq, 32'h0);
    rdc(`GDIO_OFF_IRQSTAT, 32'h2);
    extVal <= 16'h0003;
    tick(4);
    chk(irq, 32'h1);
    rdc(`GDIO_OFF_IRQSTAT, 32'h1);
    chk(irq, 32'h0);
    sleepDeep <= 1'b1;
    tick(4);
    rdc(`GDIO_OFF_LVL0, 32'h0);
    wr(`GDIO_OFF_EXTEN, 32'h1);
    rdc(`GDIO_OFF_LVL0, 32'h1);
    wr(`GDIO_OFF_EXTEN, 32'h0);
    rdc(`GDIO_OFF_IRQSTAT, 32'h1);
    sleepDeep <= 1'b0;
    tick(4);
    rdc(`GDIO_OFF_IRQSTAT, 32'h3);
    wr(`GDIO_OFF_DRV0, 32'h0f);
    rst_n = 1'b0;
    #1;
    chk({padOe, padPullup}, 32'h0);
    tick(2);
    rst_n <= 1'b1;
    tick(4);
    rdc(`GDIO_OFF_DRV0, 32'h0);
    finish_test();
  end
endmodule
bind gdio_port gdio_port_assertions chk_u (.clk_sys(clk_sys),
  .rst_n(rst_n), .awvalid(awvalid), .awready(awready), .wready(wready),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .padOe(padOe), .padPullup(padPullup));
